// ### logic/lqt_pkg.sv
// package: address map, field layout and pattern codes for the link quality test block
package lqt_pkg;
    localparam int          ADDR_W            = 20;
    localparam int          CNT_W             = 15;
    localparam int          LANES             = 4;
    // sink_config_space addresses
    localparam logic [19:0] TRAIN_SET_ADDR    = 20'h0_0102;
    localparam logic [19:0] LANE0_COUNT_ADDR  = 20'h0_0210;
    localparam logic [19:0] LANE2_LOW_ADDR    = 20'h0_0214;
    localparam logic [19:0] LANE2_HIGH_ADDR   = 20'h0_0215;
    localparam logic [19:0] LANE3_LOW_ADDR    = 20'h0_0216;
    localparam logic [19:0] LANE3_HIGH_ADDR   = 20'h0_0217;
    localparam logic [19:0] TEST_RSVD_LO      = 20'h0_0218;
    localparam logic [19:0] TEST_RSVD_HI      = 20'h0_027F;
    localparam logic [19:0] PROT_LO           = 20'h8_0000;
    localparam logic [19:0] PROT_HI           = 20'h8_0FFF;
    localparam logic [19:0] REMOTE_LO         = 20'h8_1000;
    localparam logic [19:0] REMOTE_HI         = 20'h8_1FFF;
    // field layout
    localparam int          VALID_BIT         = 7;
    localparam int          QUAL_LSB          = 2;
    localparam logic [1:0]  QUAL_NONE         = 2'h0;
    localparam logic [1:0]  QUAL_NYQUIST      = 2'h1;
    localparam logic [1:0]  QUAL_SER          = 2'h2;
    localparam logic [7:0]  TRAIN_SET_RESET   = 8'h00;
    localparam logic [7:0]  SER_EXPECTED      = 8'h00;
    localparam logic [7:0]  READ_ZERO         = 8'h00;
    localparam logic [14:0] CNT_RESET         = 15'h0000;
endpackage

// ### logic/lane_error_counter.sv
// module: one lane's saturating symbol error counter with valid flag
`timescale 1ns/1ps
module lane_error_counter #(
    parameter int CNT_W = lqt_pkg::CNT_W
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             restart_i,
    input  wire logic             measure_i,
    input  wire logic             sym_valid_i,
    input  wire logic             sym_ctrl_i,
    input  wire logic [7:0]       sym_data_i,
    input  wire logic             locked_i,
    output logic      [CNT_W-1:0] count_o,
    output logic                  valid_o
);
    initial begin
        if (CNT_W < 2 || CNT_W > 15) $error("CNT_W out of range");
    end

    logic [CNT_W-1:0] count_reg;
    logic             valid_reg;
    wire              sat      = &count_reg;
    // control symbols are framing, not payload, so they never count
    wire              mismatch = measure_i && locked_i && sym_valid_i && !sym_ctrl_i
                                 && (sym_data_i != lqt_pkg::SER_EXPECTED);

    always_ff @(posedge clk_i) begin
        if (rst_i || restart_i) begin
            count_reg <= '0;
        end else if (mismatch && !sat) begin
            count_reg <= count_reg + 1'b1;
        end
    end

    // the count only means something while measuring on a locked lane
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            valid_reg <= 1'b0;
        end else begin
            valid_reg <= measure_i && locked_i;
        end
    end

    assign count_o = count_reg;
    assign valid_o = valid_reg;
endmodule // lane_error_counter

// ### logic/link_quality_test.sv
// module: sink-side link quality test, error counters and config-space read decode
`timescale 1ns/1ps
module link_quality_test #(
    parameter int LANES = lqt_pkg::LANES
) (
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    // register access from the auxiliary_channel transaction layer
    input  wire logic                    reg_req_i,
    input  wire logic                    reg_wr_i,
    input  wire logic [19:0]             reg_addr_i,
    input  wire logic [7:0]              reg_wdata_i,
    output logic                         reg_ack_o,
    output logic      [7:0]              reg_rdata_o,
    // decoded main link symbols, one per lane per cycle, after descrambling
    input  wire logic [LANES-1:0]        sym_valid_i,
    input  wire logic [LANES-1:0]        sym_ctrl_i,
    input  wire logic [LANES*8-1:0]      sym_data_i,
    input  wire logic [LANES-1:0]        lane_locked_i,
    // link status from training: set once training has completed
    input  wire logic                    training_done_i,
    // status to the rest of the sink
    output logic                         display_blank_o,
    output logic                         receiver_enable_o,
    output logic                         idle_accept_o,
    output logic      [1:0]              quality_pattern_o
);
    initial begin
        if (LANES != 4) $error("LANES must be 4: counters at 00214h..00217h assume four lanes");
    end

    // ===========================================================
    // pattern select from the training pattern set byte
    // ===========================================================
    logic [7:0]  train_set_reg;
    logic [1:0]  prev_pattern_reg;
    wire         wr_train   = reg_req_i && reg_wr_i && (reg_addr_i == lqt_pkg::TRAIN_SET_ADDR);
    wire  [1:0]  pattern    = train_set_reg[lqt_pkg::QUAL_LSB +: 2];
    wire         measuring  = (pattern == lqt_pkg::QUAL_SER);
    wire         nyquist    = (pattern == lqt_pkg::QUAL_NYQUIST);
    // a fresh measurement starts on entry into the error rate pattern
    wire         restart    = measuring && (prev_pattern_reg != lqt_pkg::QUAL_SER);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            train_set_reg <= lqt_pkg::TRAIN_SET_RESET;
        end else if (wr_train) begin
            train_set_reg <= reg_wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_pattern_reg <= lqt_pkg::QUAL_NONE;
        end else begin
            prev_pattern_reg <= pattern;
        end
    end

    // ===========================================================
    // per-lane counters
    // ===========================================================
    logic [LANES*15-1:0] count_w;
    logic [LANES-1:0]    valid_w;

    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            lane_error_counter #(
                .CNT_W (lqt_pkg::CNT_W)
            ) u_cnt (
                .clk_i       (clk_i),
                .rst_i       (rst_i),
                .restart_i   (restart),
                .measure_i   (measuring),
                .sym_valid_i (sym_valid_i[g]),
                .sym_ctrl_i  (sym_ctrl_i[g]),
                .sym_data_i  (sym_data_i[g*8 +: 8]),
                .locked_i    (lane_locked_i[g]),
                .count_o     (count_w[g*15 +: 15]),
                .valid_o     (valid_w[g])
            );
        end
    endgenerate

    // ===========================================================
    // read decode
    // ===========================================================
    wire [14:0] cnt2 = count_w[2*15 +: 15];
    wire [14:0] cnt3 = count_w[3*15 +: 15];
    wire [7:0]  lane2_low  = cnt2[7:0];
    wire [7:0]  lane2_high = {valid_w[2], cnt2[14:8]};
    wire [7:0]  lane3_low  = cnt3[7:0];
    wire [7:0]  lane3_high = {valid_w[3], cnt3[14:8]};
    wire        in_test_rsvd = (reg_addr_i >= lqt_pkg::TEST_RSVD_LO)
                               && (reg_addr_i <= lqt_pkg::TEST_RSVD_HI);
    // the protection and remote-command windows belong to other blocks; here they read zero
    wire        in_services  = (reg_addr_i >= lqt_pkg::PROT_LO)
                               && (reg_addr_i <= lqt_pkg::REMOTE_HI);
    logic [7:0] rdata_next;

    // a sink has no downstream links, so its space reflects only its own state
    always_comb begin
        if (reg_addr_i == lqt_pkg::LANE2_LOW_ADDR) begin
            rdata_next = lane2_low;
        end else if (reg_addr_i == lqt_pkg::LANE2_HIGH_ADDR) begin
            rdata_next = lane2_high;
        end else if (reg_addr_i == lqt_pkg::LANE3_LOW_ADDR) begin
            rdata_next = lane3_low;
        end else if (reg_addr_i == lqt_pkg::LANE3_HIGH_ADDR) begin
            rdata_next = lane3_high;
        end else if (reg_addr_i == lqt_pkg::TRAIN_SET_ADDR) begin
            rdata_next = train_set_reg;
        end else if (in_test_rsvd) begin
            rdata_next = lqt_pkg::READ_ZERO;
        end else if (in_services) begin
            rdata_next = lqt_pkg::READ_ZERO;
        end else begin
            rdata_next = lqt_pkg::READ_ZERO;
        end
    end

    // read-only and reserved addresses accept writes silently
    logic [7:0] rdata_reg;
    logic       ack_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_reg <= lqt_pkg::READ_ZERO;
            ack_reg   <= 1'b0;
        end else begin
            ack_reg   <= reg_req_i;
            if (reg_req_i && !reg_wr_i) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    // ===========================================================
    // sink status outputs
    // ===========================================================
    logic blank_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            blank_reg <= 1'b0;
        end else begin
            blank_reg <= nyquist;
        end
    end

    assign reg_ack_o         = ack_reg;
    assign reg_rdata_o       = rdata_reg;
    assign display_blank_o   = blank_reg;
    assign receiver_enable_o = 1'b1;
    // idle is accepted from the very cycle training is reported done
    // a pre-calibrated link reports done without training and is treated the same
    assign idle_accept_o     = training_done_i;
    assign quality_pattern_o = pattern;
endmodule // link_quality_test

// ### sim/lqt_sva.sv
// checker: port timing of the link quality test block
`timescale 1ns/1ps
module lqt_sva (
    input logic        clk_i,
    input logic        rst_i,
    input logic        reg_req_i,
    input logic        reg_wr_i,
    input logic [19:0] reg_addr_i,
    input logic [7:0]  reg_wdata_i,
    input logic        reg_ack_o,
    input logic [7:0]  reg_rdata_o,
    input logic        training_done_i,
    input logic        display_blank_o,
    input logic        receiver_enable_o,
    input logic        idle_accept_o,
    input logic [1:0]  quality_pattern_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire rd_req = reg_req_i && !reg_wr_i;
    wire set_wr = reg_req_i && reg_wr_i && reg_addr_i == lqt_pkg::TRAIN_SET_ADDR;
    wire tst_rsv = reg_addr_i >= lqt_pkg::TEST_RSVD_LO && reg_addr_i <= lqt_pkg::TEST_RSVD_HI;
    wire svc_rsv = reg_addr_i >= lqt_pkg::PROT_LO && reg_addr_i <= lqt_pkg::REMOTE_HI;
    ack_once_a: assert property (reg_req_i |=> reg_ack_o) else $error("missing ack");
    ack_quiet_a: assert property (!reg_req_i |=> !reg_ack_o) else $error("stray ack");
    test_zero_a: assert property (rd_req && tst_rsv |=> reg_rdata_o == 8'h00)
        else $error("test area read nonzero");
    svc_zero_a: assert property (rd_req && svc_rsv |=> reg_rdata_o == 8'h00)
        else $error("services area read nonzero");
    rdata_hold_a: assert property (!rd_req |=> $stable(reg_rdata_o))
        else $error("read data moved");
    pattern_set_a: assert property (set_wr |=>
        quality_pattern_o == $past(reg_wdata_i[3:2])) else $error("pattern not taken");
    pattern_keep_a: assert property (!set_wr |=> $stable(quality_pattern_o))
        else $error("pattern moved");
    blank_follow_a: assert property (1'b1 |=> display_blank_o ==
        ($past(quality_pattern_o) == lqt_pkg::QUAL_NYQUIST)) else $error("blank wrong");
    rx_on_a: assert property (receiver_enable_o) else $error("receiver off");
    idle_ready_a: assert property (idle_accept_o == training_done_i)
        else $error("idle accept wrong");
    valid_off_a: assert property (rd_req && reg_addr_i == lqt_pkg::LANE2_HIGH_ADDR
        && $past(quality_pattern_o) != lqt_pkg::QUAL_SER |=> !reg_rdata_o[7])
        else $error("valid set outside measurement");
endmodule // lqt_sva
bind link_quality_test lqt_sva chk (.*);

// ### sim/lqt_source_model.sv
// model: source side main link symbol generator
`timescale 1ns/1ps
module lqt_source_model (
    input  logic        clk_i,
    input  logic        run_i,
    input  logic        ctrl_i,
    input  logic        nyq_i,
    input  logic [3:0]  err_i,
    output logic [3:0]  sym_valid_o,
    output logic [3:0]  sym_ctrl_o,
    output logic [31:0] sym_data_o
);
    // D10.2 as a data byte: the lane toggles at its highest rate
    localparam logic [7:0] NYQ_SYM = 8'h4A;
    // the stream format is fixed here: no legacy identity data to choose
    initial {sym_valid_o, sym_ctrl_o, sym_data_o} = '0;
    // launch mid-cycle so the sink samples settled symbols
    always @(negedge clk_i) begin
        #1;
        sym_valid_o = {4{run_i}};
        sym_ctrl_o = {4{ctrl_i}};
        for (int g = 0; g < 4; g++) begin
            // clean stream is 00h; idle lines keep changing
            if (run_i && nyq_i) begin
                sym_data_o[8*g+:8] = NYQ_SYM;
            end else begin
                sym_data_o[8*g+:8] = (run_i && !err_i[g]) ? 8'h00 : 8'(1 + $urandom % 255);
            end
        end
    end
endmodule // lqt_source_model

// ### sim/test_link_quality_test_and_error_count.sv
// testbench: register reads, pattern control and lane error counting
`timescale 1ns/1ps
module test_link_quality_test_and_error_count;
    localparam logic [19:0] STATUS_LO = 20'h0_0200;
    localparam logic [19:0] CNT_BASE  = lqt_pkg::LANE2_LOW_ADDR;
    logic        clk_i = 0, rst_i = 1, req = 0, wr = 0, run = 0, ctrl = 0, done = 1, nyq = 0;
    logic [19:0] addr = '0;
    logic [7:0]  wdata = '0, rdata, rd;
    logic [3:0]  err = '0, lock = '1, sv, sc;
    logic [31:0] sd;
    logic        ack, blank, rx_en, idle;
    logic [1:0]  pat;
    int          err_total = 0, samples_checked = 0;
    lqt_source_model src (.clk_i(clk_i), .run_i(run), .ctrl_i(ctrl), .nyq_i(nyq), .err_i(err),
        .sym_valid_o(sv), .sym_ctrl_o(sc), .sym_data_o(sd));
    link_quality_test DUT (.clk_i(clk_i), .rst_i(rst_i), .reg_req_i(req), .reg_wr_i(wr),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_ack_o(ack), .reg_rdata_o(rdata),
        .sym_valid_i(sv), .sym_ctrl_i(sc), .sym_data_i(sd), .lane_locked_i(lock),
        .training_done_i(done), .display_blank_o(blank), .receiver_enable_o(rx_en),
        .idle_accept_o(idle), .quality_pattern_o(pat));
    initial forever #2 clk_i = ~clk_i;
    // ====================================
    // shared tasks
    task automatic end_of_test();
        if (err_total == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic check(string name, logic [7:0] exp, logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic access(logic w, logic [19:0] a, logic [7:0] d);
        @(negedge clk_i);
        req = 1;
        wr = w;
        addr = a;
        wdata = d;
        @(negedge clk_i);
        req = 0;
        for (int i = 0; ack !== 1'b1; i++) begin
            if (i == 8) begin
                err_total++;
                end_of_test();
            end
            @(posedge clk_i);
            #1;
        end
        rd = rdata;
    endtask
    task automatic rdchk(string n, logic [19:0] a, logic [7:0] exp);
        access(1'b0, a, 8'h00);
        check(n, exp, rd);
    endtask
    task automatic burst(logic [3:0] m, logic c, int n);
        @(negedge clk_i);
        run = 1;
        ctrl = c;
        err = m;
        repeat (n) @(negedge clk_i);
        run = 0;
    endtask
    // count bytes as seen at the bus, saturating at the 15-bit top
    function automatic logic [7:0] exp_byte(int n, logic hi, logic v);
        logic [14:0] c;
        c = (n > 32767) ? 15'h7fff : 15'(n);
        return hi ? {v, c[14:8]} : c[7:0];
    endfunction
    initial begin
        int n2, n3, n;
        void'($urandom(84010));
        repeat (12) @(posedge clk_i);
        @(negedge clk_i);
        rst_i = 0;
        for (int i = 0; i < 4; i++) begin
            rdchk("count_reset", CNT_BASE + 20'(i), 8'h00);
        end
        for (int i = 0; i < 16; i++) begin
            addr = i[0] ? lqt_pkg::TEST_RSVD_LO + 20'($urandom % 'h68)
                        : lqt_pkg::PROT_LO + 20'($urandom % 'h2000);
            access(1'b1, addr, 8'hff);
            rdchk("reserved", addr, 8'h00);
        end
        // hot plug interrupt: training drops, then link status is read back
        done = 0;
        @(negedge clk_i);
        check("idle_accept", 8'h00, {7'h00, idle});
        for (int i = 0; i < 6; i++) begin
            rdchk("link_status", STATUS_LO + 20'(i), 8'h00);
        end
        done = 1;
        @(negedge clk_i);
        check("idle_accept", 8'h01, {7'h00, idle});
        access(1'b1, lqt_pkg::TRAIN_SET_ADDR, 8'h04);
        @(negedge clk_i);
        check("pattern", {6'h00, lqt_pkg::QUAL_NYQUIST}, {6'h00, pat});
        check("blank", 8'h01, {7'h00, blank});
        check("receiver", 8'h01, {7'h00, rx_en});
        nyq = 1;
        burst(4'hf, 1'b0, 20);
        nyq = 0;
        access(1'b1, lqt_pkg::TRAIN_SET_ADDR, 8'h08);
        n2 = 200 + $urandom % 400;
        n3 = 1 + $urandom % 300;
        burst(4'h4, 1'b0, n2);
        burst(4'h8, 1'b0, n3);
        burst(4'hf, 1'b1, 30);
        access(1'b1, lqt_pkg::LANE2_LOW_ADDR, 8'hff);
        rdchk("lane2_low", CNT_BASE, exp_byte(n2, 1'b0, 1'b1));
        rdchk("lane2_high", CNT_BASE + 20'h1, exp_byte(n2, 1'b1, 1'b1));
        rdchk("lane3_low", CNT_BASE + 20'h2, exp_byte(n3, 1'b0, 1'b1));
        rdchk("lane3_high", CNT_BASE + 20'h3, exp_byte(n3, 1'b1, 1'b1));
        access(1'b1, lqt_pkg::TRAIN_SET_ADDR, 8'h00);
        // idle pattern: a blank start symbol, then 8 random nonzero data bytes on every lane
        burst(4'hf, 1'b1, 1);
        burst(4'hf, 1'b0, 8);
        rdchk("idle_low", CNT_BASE, exp_byte(n2, 1'b0, 1'b0));
        rdchk("idle_high", CNT_BASE + 20'h1, exp_byte(n2, 1'b1, 1'b0));
        lock[3] = 0;
        access(1'b1, lqt_pkg::TRAIN_SET_ADDR, 8'h08);
        burst(4'hc, 1'b0, 32770);
        for (int i = 0; i < 4; i++) begin
            n = (i < 2) ? 32770 : 0;
            rdchk("saturate", CNT_BASE + 20'(i), exp_byte(n, i[0], n > 0));
        end
        end_of_test();
    end
endmodule // test_link_quality_test_and_error_count
